// *** eeb_pkg.sv ***
// Purpose: shared constants for the two-wire eeprom bus, host and slave ends
// Assumes: 8-bit register port on the host side, open-drain lines on the link
// Notes:   one place for every offset, bit position and size
package eeb_pkg;

	////////////////////////////////////////////////////////////////////////////
	// host register port
	localparam int          EEB_ADDR_W       = 8;
	localparam int          EEB_DATA_W       = 8;
	localparam logic [7:0]  EEB_PORT_OFS     = 8'h90; // eeprom_bus_port
	localparam logic [7:0]  EEB_PORT_RST     = 8'h03; // both lines released
	localparam int          EEB_SDA_DRV_BIT  = 0;     // write: sda level to drive
	localparam int          EEB_SCL_DRV_BIT  = 1;     // write: scl level to drive
	localparam int          EEB_SDA_LINE_BIT = 2;     // read: sda line as seen
	localparam int          EEB_SCL_LINE_BIT = 3;     // read: scl line as seen
	localparam int          EEB_BUSY_BIT     = 4;     // read: transfer in progress

	////////////////////////////////////////////////////////////////////////////
	// slave side
	localparam int          EEB_BUF_DEPTH    = 16;    // write bytes kept
	localparam int          EEB_CODE_W       = 4;     // device type code width
	localparam logic [3:0]  EEB_CODE_DEF     = 4'h5;  // arbitrary value
	localparam int          EEB_CODE_MSB     = 7;     // code sits in bits 7..4
	localparam int          EEB_RW_BIT       = 0;     // last bit: 1 read, 0 write
	localparam logic [3:0]  EEB_BITS_BYTE    = 4'h8;

endpackage

// *** eeb_if.sv ***
// Purpose: open-drain two-wire link between bus master and eeprom slave
// Assumes: every driver only ever pulls low; released lines float high
// Notes:   the wired-and level is worked out here, not in the ends
`timescale 1ns/1ps
interface eeb_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// wired-and with pull-ups
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host
	(
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe,
		input  scl,
		input  sda
	);

	modport dev
	(
		output dev_sda_o,
		output dev_sda_oe,
		input  scl,
		input  sda
	);
endinterface

// *** eeb_host.sv ***
// Purpose: bus master end, lines moved by software through eeprom_bus_port
// Assumes: single master; software paces scl slowly against the slave clock
// Notes:   clock edges and data changes are ordered in hardware
`timescale 1ns/1ps
module eeb_host
	import eeb_pkg::*;
(
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic [eeb_pkg::EEB_ADDR_W-1:0] addr,
	input  wire logic [eeb_pkg::EEB_DATA_W-1:0] wdata,
	input  wire logic                           wr,
	input  wire logic                           rd,
	output      logic [eeb_pkg::EEB_DATA_W-1:0] rdata,
	eeb_if.host                                 link
);
	import eeb_pkg::*;

	typedef struct packed
	{
		logic                  scl_s1;
		logic                  scl_s2;
		logic                  sda_s1;
		logic                  sda_s2;
		logic                  scl_p;
		logic                  sda_p;
		logic                  scl_v;
		logic                  sda_v;
		logic                  scl_pend;
		logic                  sda_pend;
		logic                  sda_new;
		logic                  busy;
		logic [EEB_DATA_W-1:0] rdata;
	} eeb_hst_t;

	eeb_hst_t st_r;
	eeb_hst_t st_nxt;

	logic     ws;
	logic     wc;
	logic     line_start;
	logic     line_stop;

	////////////////////////////////////////////////////////////////////////////
	// line watch, register port and edge ordering
	always_comb
	begin
		st_nxt        = st_r;
		st_nxt.scl_s1 = link.scl;
		st_nxt.scl_s2 = st_r.scl_s1;
		st_nxt.sda_s1 = link.sda;
		st_nxt.sda_s2 = st_r.sda_s1;
		st_nxt.scl_p  = st_r.scl_s2;
		st_nxt.sda_p  = st_r.sda_s2;
		ws            = wdata[EEB_SDA_DRV_BIT];
		wc            = wdata[EEB_SCL_DRV_BIT];
		line_start    = st_r.scl_s2 & st_r.scl_p & st_r.sda_p & ~st_r.sda_s2;
		line_stop     = st_r.scl_s2 & st_r.scl_p & ~st_r.sda_p & st_r.sda_s2;
		// busy from seen conditions; set from own start below as well
		if (line_start)
			st_nxt.busy = 1'b1;
		else if (line_stop)
			st_nxt.busy = 1'b0;
		// deferred half of a two-line write
		if (st_r.sda_pend)
		begin
			st_nxt.sda_v    = st_r.sda_new;
			st_nxt.sda_pend = 1'b0;
		end
		if (st_r.scl_pend)
		begin
			st_nxt.scl_v    = 1'b1;
			st_nxt.scl_pend = 1'b0;
		end
		st_nxt.rdata = '0;
		if (rd && addr == EEB_PORT_OFS)
		begin
			st_nxt.rdata[EEB_SDA_DRV_BIT]  = st_r.sda_v;
			st_nxt.rdata[EEB_SCL_DRV_BIT]  = st_r.scl_v;
			st_nxt.rdata[EEB_SDA_LINE_BIT] = st_r.sda_s2;
			st_nxt.rdata[EEB_SCL_LINE_BIT] = st_r.scl_s2;
			st_nxt.rdata[EEB_BUSY_BIT]     = st_r.busy;
		end
		if (wr && addr == EEB_PORT_OFS)
		begin
			if (!wc)
			begin
				// scl falls first, sda follows in the low phase
				st_nxt.scl_v    = 1'b0;
				st_nxt.scl_pend = 1'b0;
				st_nxt.sda_pend = 1'b1;
				st_nxt.sda_new  = ws;
			end
			else if (!st_r.scl_v)
			begin
				// sda settles before scl rises
				st_nxt.sda_v    = ws;
				st_nxt.sda_pend = 1'b0;
				st_nxt.scl_pend = 1'b1;
			end
			else if (st_r.sda_v && !ws)
			begin
				// start only on an idle bus, both lines high
				if (!st_r.busy && st_r.sda_s2 && st_r.scl_s2)
				begin
					st_nxt.sda_v = 1'b0;
					st_nxt.busy  = 1'b1;
				end
			end
			else
				st_nxt.sda_v = ws;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			st_r <= '{scl_v: 1'b1, sda_v: 1'b1, default: '0};
		else
			st_r <= st_nxt;
	end

	assign rdata            = st_r.rdata;
	assign link.host_scl_o  = 1'b0;
	assign link.host_scl_oe = ~st_r.scl_v;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = ~st_r.sda_v;
endmodule

// *** eeb_dev.sv ***
// Purpose: eeprom slave end of the two-wire bus, with a write byte buffer
// Assumes: runs on link_clk; scl phases last several link_clk periods
// Notes:   lines are oversampled, so start and stop are seen as sda edges
`timescale 1ns/1ps
module eeb_dev
	import eeb_pkg::*;
#(
	parameter int         DEPTH    = eeb_pkg::EEB_BUF_DEPTH,
	parameter logic [3:0] DEV_CODE = eeb_pkg::EEB_CODE_DEF // arbitrary value
)
(
	input  wire logic                     link_clk,
	input  wire logic                     rst_n,
	input  wire logic                     prog_busy,
	input  wire logic [7:0]               rd_byte,
	output      logic                     rd_take,
	input  wire logic [$clog2(DEPTH)-1:0] buf_idx,
	output      logic [7:0]               buf_data,
	output      logic [$clog2(DEPTH):0]   buf_count,
	output      logic [$clog2(DEPTH)-1:0] buf_head,
	output      logic                     wr_done,
	output      logic                     bus_active,
	eeb_if.dev                            link
);
	import eeb_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

	typedef enum logic [2:0]
	{
		S_IDLE,
		S_CTRL,
		S_WDATA,
		S_ACK,
		S_RDATA,
		S_RACK
	} eeb_st_t;

	typedef struct packed
	{
		eeb_st_t                state;
		logic                   scl_s1;
		logic                   scl_s2;
		logic                   sda_s1;
		logic                   sda_s2;
		logic                   scl_p;
		logic                   sda_p;
		logic [7:0]             shreg;
		logic [3:0]             bcnt;
		logic                   rw;
		logic                   acked;
		logic                   sda_oe;
		logic                   wrote;
		logic [PW-1:0]          wptr;
		logic [PW:0]            cnt;
		logic [DEPTH-1:0][7:0]  mem;
		logic [7:0]             buf_q;
		logic                   rd_take;
		logic                   wr_done;
	} eeb_dev_t;

	eeb_dev_t st_r;
	eeb_dev_t st_nxt;

	logic       scl_rise;
	logic       scl_fall;
	logic       cond_start;
	logic       cond_stop;
	logic [7:0] byte_in;
	logic       ack_ok;

	////////////////////////////////////////////////////////////////////////////
	// line sampling and bus conditions
	always_comb
	begin
		st_nxt         = st_r;
		st_nxt.rd_take = 1'b0;
		st_nxt.wr_done = 1'b0;
		// first stage feeds the second only
		st_nxt.scl_s1  = link.scl;
		st_nxt.scl_s2  = st_r.scl_s1;
		st_nxt.sda_s1  = link.sda;
		st_nxt.sda_s2  = st_r.sda_s1;
		st_nxt.scl_p   = st_r.scl_s2;
		st_nxt.sda_p   = st_r.sda_s2;
		st_nxt.buf_q   = st_r.mem[buf_idx];
		scl_rise       = st_r.scl_s2 & ~st_r.scl_p;
		scl_fall       = ~st_r.scl_s2 & st_r.scl_p;
		// sda moving while scl stays high is never data
		cond_start     = st_r.scl_s2 & st_r.scl_p & st_r.sda_p & ~st_r.sda_s2;
		cond_stop      = st_r.scl_s2 & st_r.scl_p & ~st_r.sda_p & st_r.sda_s2;
		byte_in        = st_r.shreg;
		// programming cycle silences every ack
		ack_ok         = ~prog_busy;
		if (st_r.state == S_CTRL)
			ack_ok = ack_ok && byte_in[EEB_CODE_MSB -: EEB_CODE_W] == DEV_CODE;

		////////////////////////////////////////////////////////////////////////
		// transfer sequencing; start and stop override any state
		if (cond_start)
		begin
			st_nxt.state  = S_CTRL;
			st_nxt.bcnt   = '0;
			st_nxt.sda_oe = 1'b0;
		end
		else if (cond_stop)
		begin
			st_nxt.wr_done = st_r.wrote;
			st_nxt.wrote   = 1'b0;
			st_nxt.state   = S_IDLE;
			st_nxt.sda_oe  = 1'b0;
		end
		else
		begin
			case (st_r.state)
				S_CTRL, S_WDATA:
				begin
					if (scl_rise)
					begin
						// sda steady over the high phase, else a condition fired
						st_nxt.shreg = {st_r.shreg[6:0], st_r.sda_s2};
						st_nxt.bcnt  = st_r.bcnt + 4'h1;
					end
					else if (scl_fall && st_r.bcnt == EEB_BITS_BYTE)
					begin
						// pull sda in the low phase ahead of the ack pulse
						st_nxt.sda_oe = ack_ok;
						st_nxt.acked  = ack_ok;
						st_nxt.state  = S_ACK;
						st_nxt.bcnt   = '0;
						if (st_r.state == S_CTRL)
							st_nxt.rw = byte_in[EEB_RW_BIT];
						else if (ack_ok)
						begin
							// circular slot, oldest overwritten on wrap
							st_nxt.mem[st_r.wptr] = byte_in;
							st_nxt.wptr           = st_r.wptr + PW'(1);
							st_nxt.wrote          = 1'b1;
							if (st_r.cnt != FULL)
								st_nxt.cnt = st_r.cnt + (PW+1)'(1);
						end
					end
				end
				S_ACK:
				begin
					if (scl_fall)
					begin
						// ack held until scl is low again
						st_nxt.sda_oe = 1'b0;
						if (!st_r.acked)
							st_nxt.state = S_IDLE;
						else if (st_r.rw)
						begin
							st_nxt.shreg   = rd_byte;
							st_nxt.sda_oe  = ~rd_byte[7];
							st_nxt.rd_take = 1'b1;
							st_nxt.bcnt    = '0;
							st_nxt.state   = S_RDATA;
						end
						else
							st_nxt.state = S_WDATA;
					end
				end
				S_RDATA:
				begin
					if (scl_fall)
					begin
						// next bit only once scl is low
						st_nxt.bcnt = st_r.bcnt + 4'h1;
						if (st_r.bcnt == EEB_BITS_BYTE - 4'h1)
						begin
							st_nxt.sda_oe = 1'b0;
							st_nxt.state  = S_RACK;
						end
						else
						begin
							st_nxt.shreg  = {st_r.shreg[6:0], 1'b0};
							st_nxt.sda_oe = ~st_r.shreg[6];
						end
					end
				end
				S_RACK:
				begin
					if (scl_rise)
					begin
						st_nxt.acked = ~st_r.sda_s2;
						if (st_r.sda_s2)
						begin
							// nack: leave sda released so the master can stop
							st_nxt.sda_oe = 1'b0;
							st_nxt.state  = S_IDLE;
						end
						else
							st_nxt.state = S_ACK;
					end
				end
				default:
				begin
					st_nxt.sda_oe = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge link_clk)
	begin
		if (!rst_n)
			st_r <= '{state: S_IDLE, default: '0};
		else
			st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs; sda is only ever pulled low
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = st_r.sda_oe;
	assign rd_take         = st_r.rd_take;
	assign wr_done         = st_r.wr_done;
	assign buf_data        = st_r.buf_q;
	assign buf_count       = st_r.cnt;
	assign buf_head        = st_r.wptr;
	assign bus_active      = st_r.state != S_IDLE;
endmodule

// *** eeb_props.sv ***
// Purpose: wire-level checks on the two-wire eeprom link
// Assumes: each scl phase lasts several link_clk periods
// Notes:   sees only the interface signals, clocks and resets
`timescale 1ns/1ps
module eeb_props
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic link_rst_n,
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic [5:0] hi_cnt_r, hi_cnt_nxt;
	////////////////////////////////////////////////
	// scl high run length, saturating so it never wraps back
	always_comb hi_cnt_nxt = scl ? hi_cnt_r + {5'h00, ~&hi_cnt_r} : 6'h00;
	always_ff @(posedge link_clk) hi_cnt_r <= link_rst_n ? hi_cnt_nxt : 6'h00;

	// host and slave only ever pull, so released lines float high
	chk_host_pull_only: assert property (@(posedge clk) disable iff (!rst_n)
		!host_scl_o && !host_sda_o) else $error("host drives a line high");
	chk_host_two_step: assert property (@(posedge clk) disable iff (!rst_n)
		!($changed(host_scl_oe) && $changed(host_sda_oe))) else $error("both lines moved at once");
	chk_dev_pull_only: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		dev_sda_oe |-> !dev_sda_o) else $error("slave drives sda high");
	chk_dev_low_phase: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		$changed(dev_sda_oe) |-> !scl) else $error("slave moved sda with scl high");
	chk_ack_steady: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		$rose(scl) && dev_sda_oe |-> (dev_sda_oe && !sda)[*4]) else $error("ack not held low");
	chk_hold_high: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		scl && $past(scl) |-> $stable(dev_sda_oe)) else $error("slave sda moved in high phase");
	chk_idle_release: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		hi_cnt_r > 6'h28 |-> !dev_sda_oe) else $error("slave holds sda on idle bus");
	chk_reset_release: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		$rose(link_rst_n) |-> !dev_sda_oe) else $error("slave pulls sda out of reset");
endmodule

// *** tb.sv ***
// Purpose: host and slave joined by the link, driven through eeprom_bus_port
// Assumes: software paces scl at 100 clk per step, many link_clk periods
// Notes:   host and slave resets are released separately
`timescale 1ns/1ps
module tb;
	import eeb_pkg::*;
	localparam logic [3:0] CODE = 4'h9; // arbitrary value
	logic clk, link_clk, rst_n, link_rst_n, wr, rd, prog_busy, rd_take, wr_done, bus_active;
	logic [7:0] addr, wdata, rdata, rd_byte, buf_data;
	logic [3:0] buf_idx, buf_head;
	logic [4:0] buf_count;
	int failures, tests_run, done_n, take_n;
	eeb_if link ();
	eeb_host u_eeb_host (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .link(link));
	eeb_dev #(.DEPTH(EEB_BUF_DEPTH), .DEV_CODE(CODE)) u_eeb_dev (.link_clk(link_clk),
		.rst_n(link_rst_n), .prog_busy(prog_busy), .rd_byte(rd_byte), .rd_take(rd_take),
		.buf_idx(buf_idx), .buf_data(buf_data), .buf_count(buf_count), .buf_head(buf_head),
		.wr_done(wr_done), .bus_active(bus_active), .link(link));
	eeb_props u_eeb_props (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
		.link_rst_n(link_rst_n), .host_scl_o(link.host_scl_o), .host_scl_oe(link.host_scl_oe),
		.host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
		.dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
	////////////////////////////////////////////////
	// clocks: link clock offset so the phases are unrelated
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #32 link_clk = ~link_clk;
	end
	// count slave pulses in their own domain, one cycle wide
	always @(posedge link_clk)
	begin
		if (wr_done === 1'b1) done_n <= done_n + 1;
		if (rd_take === 1'b1) take_n <= take_n + 1;
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wport(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rport(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic put(input logic c, input logic d);
		wport(EEB_PORT_OFS, {6'h00, c, d});
		repeat (100) @(posedge clk);
	endtask
	task automatic bit_x(input logic b, output logic r);
		logic [7:0] v;
		put(1'b0, b);
		put(1'b1, b);
		rport(EEB_PORT_OFS, v);
		r = v[EEB_SDA_LINE_BIT];
	endtask
	// msb first, then the ninth pulse for the acknowledge
	task automatic byte_x(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
		output logic a);
		for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
		bit_x(ak, a);
	endtask
	task automatic stop;
		put(1'b0, 1'b0);
		put(1'b1, 1'b0);
		put(1'b1, 1'b1);
	endtask
	initial
	begin
		#450000;
		failures++;
		conclude();
	end
	////////////////////////////////////////////////
	initial
	begin
		logic [7:0] v, rx;
		logic a;
		{rst_n, link_rst_n, wr, rd, prog_busy} = 5'h00;
		{addr, wdata, buf_idx} = 20'h00000;
		rd_byte = 8'h5a;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge link_clk);
		link_rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		rport(EEB_PORT_OFS, v);
		check("port idle", v, 8'h0f);
		wport(8'h91, 8'h00);
		rport(8'h91, v);
		check("unmapped", v, 8'h00);
		// write of 18 bytes: ring keeps the last 16
		put(1'b1, 1'b0);
		check("active", {7'h00, bus_active}, 8'h01);
		byte_x({CODE, 3'b101, 1'b0}, 1'b1, rx, a);
		check("ctl ack", {7'h00, a}, 8'h00);
		for (int k = 0; k < 18; k++)
		begin
			byte_x(8'h10 + 8'(k), 1'b1, rx, a);
			check("data ack", {7'h00, a}, 8'h00);
		end
		stop();
		check("done", 8'(done_n), 8'h01);
		check("idle", {7'h00, bus_active}, 8'h00);
		check("count", {3'h0, buf_count}, 8'h10);
		check("head", {4'h0, buf_head}, 8'h02);
		for (int j = 0; j < 16; j++)
		begin
			buf_idx <= 4'(j);
			repeat (4) @(posedge link_clk);
			check("slot", buf_data, j < 2 ? 8'h20 + 8'(j) : 8'h10 + 8'(j));
		end
		// wrong code, then right code while programming
		put(1'b1, 1'b0);
		byte_x({~CODE, 4'h0}, 1'b1, rx, a);
		check("bad code", {7'h00, a}, 8'h01);
		// no stop seen yet, so a second start must be refused
		put(1'b1, 1'b0);
		rport(EEB_PORT_OFS, v);
		check("start refused", v, 8'h1f);
		stop();
		prog_busy <= 1'b1;
		put(1'b1, 1'b0);
		byte_x({CODE, 4'h0}, 1'b1, rx, a);
		check("prog nack", {7'h00, a}, 8'h01);
		stop();
		prog_busy <= 1'b0;
		// read two bytes, nack the last
		put(1'b1, 1'b0);
		byte_x({CODE, 4'h1}, 1'b1, rx, a);
		check("rd ctl ack", {7'h00, a}, 8'h00);
		byte_x(8'hff, 1'b0, rx, a);
		check("rd byte0", rx, 8'h5a);
		// last bit zero, so a slave still pulling after the nack would show
		rd_byte <= 8'h3c;
		byte_x(8'hff, 1'b1, rx, a);
		check("rd byte1", rx, 8'h3c);
		rport(EEB_PORT_OFS, v);
		check("released", {7'h00, v[EEB_SDA_LINE_BIT]}, 8'h01);
		stop();
		check("takes", 8'(take_n), 8'h02);
		rport(EEB_PORT_OFS, v);
		check("port end", v, 8'h0f);
		conclude();
	end
endmodule
